// [design/tws_slave.sv]
// Purpose: Two-wire bus slave that exposes a six-location register pointer port.
// Assumes: ref_clk is far faster than SCL; rd_data follows reg_ptr combinationally.
// Notes: SCL is never stretched; SDA is driven low only through sda_oe.
`timescale 1ns/1ps
module tws_slave (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Two-wire bus pins.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Register side.
    output logic [7:0] reg_ptr,
    output logic wr_strobe,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_strobe,
    input wire logic [7:0] rd_data,
    // Power monitor.
    input wire logic power_fail
);
    import tws_pkg::*;

    logic scl_m_r, scl_s_r, scl_d_r;
    logic sda_m_r, sda_s_r, sda_d_r;
    logic scl_rise, scl_fall, start_det, stop_det;

    tws_state_e state_r, state_nxt;
    tws_phase_e phase_r, phase_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic dir_r, dir_nxt;
    logic mack_r, mack_nxt;
    logic oe_r, oe_nxt;
    logic wr_stb_r, wr_stb_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [7:0] wr_data_r, wr_data_nxt;
    logic rd_stb_r, rd_stb_nxt;

    // Two-stage synchronisers plus a delayed copy for edge detection; only the
    // second stage and later are looked at, so metastability stays contained.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end

    // Bus events decoded from the synchronised lines.
    assign scl_rise = scl_s_r & ~scl_d_r;
    assign scl_fall = ~scl_s_r & scl_d_r;
    assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    assign stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

    // Transfer sequencer; START and STOP override every state.
    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        ptr_nxt = ptr_r;
        dir_nxt = dir_r;
        mack_nxt = mack_r;
        oe_nxt = oe_r;
        wr_stb_nxt = 1'b0;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        rd_stb_nxt = 1'b0;
        if (start_det) begin
            // A repeated START is handled exactly like a first one.
            state_nxt = TWS_ST_RX;
            phase_nxt = TWS_PH_ADDR;
            bit_cnt_nxt = 3'h0;
            oe_nxt = 1'b0;
        end else if (stop_det) begin
            state_nxt = TWS_ST_IDLE;
            oe_nxt = 1'b0;
        end else begin
            case (state_r)
                TWS_ST_IDLE: begin
                    oe_nxt = 1'b0;
                end
                TWS_ST_RX: begin
                    // Sample on the rising edge, once per clock pulse.
                    if (scl_rise) begin
                        shift_nxt = {shift_r[TWS_MSB-1:0], sda_s_r};
                        bit_cnt_nxt = bit_cnt_r + 3'h1;
                        if (bit_cnt_r == TWS_LAST_BIT) begin
                            state_nxt = TWS_ST_RXEND;
                        end
                    end
                end
                TWS_ST_RXEND: begin
                    // Acknowledge is set up in the low phase after the eighth bit.
                    if (scl_fall) begin
                        case (phase_r)
                            TWS_PH_ADDR: begin
                                if (shift_r[TWS_MSB:1] == TWS_SLAVE_ADDR && !power_fail) begin
                                    dir_nxt = shift_r[TWS_DIR_POS];
                                    oe_nxt = 1'b1;
                                    state_nxt = TWS_ST_ACK;
                                end else begin
                                    state_nxt = TWS_ST_IGNORE;
                                end
                            end
                            TWS_PH_PTR: begin
                                if (!power_fail) begin
                                    ptr_nxt = shift_r;
                                    oe_nxt = 1'b1;
                                    state_nxt = TWS_ST_ACK;
                                end else begin
                                    state_nxt = TWS_ST_IGNORE;
                                end
                            end
                            default: begin
                                if (!power_fail) begin
                                    wr_stb_nxt = 1'b1;
                                    wr_addr_nxt = ptr_r;
                                    wr_data_nxt = shift_r;
                                    ptr_nxt = tws_next_ptr(ptr_r);
                                    oe_nxt = 1'b1;
                                    state_nxt = TWS_ST_ACK;
                                end else begin
                                    state_nxt = TWS_ST_IGNORE;
                                end
                            end
                        endcase
                    end
                end
                TWS_ST_ACK: begin
                    // Hold SDA low for the whole ninth pulse; on its fall release it, or drive the first read bit.
                    if (scl_fall) begin
                        bit_cnt_nxt = 3'h0;
                        if (phase_r == TWS_PH_ADDR && dir_r == TWS_DIR_READ) begin
                            shift_nxt = rd_data;
                            rd_stb_nxt = 1'b1;
                            ptr_nxt = tws_next_ptr(ptr_r);
                            oe_nxt = ~rd_data[TWS_MSB];
                            state_nxt = TWS_ST_TX;
                        end else begin
                            oe_nxt = 1'b0;
                            phase_nxt = (phase_r == TWS_PH_ADDR) ? TWS_PH_PTR : TWS_PH_DATA;
                            state_nxt = TWS_ST_RX;
                        end
                    end
                end
                TWS_ST_TX: begin
                    // Shift the next bit out only while SCL is low.
                    if (scl_fall) begin
                        if (bit_cnt_r == TWS_LAST_BIT) begin
                            oe_nxt = 1'b0;
                            state_nxt = TWS_ST_TXACK;
                        end else begin
                            shift_nxt = {shift_r[TWS_MSB-1:0], 1'b0};
                            oe_nxt = ~shift_r[TWS_MSB-1];
                            bit_cnt_nxt = bit_cnt_r + 3'h1;
                        end
                    end
                end
                TWS_ST_TXACK: begin
                    if (scl_rise) begin
                        mack_nxt = ~sda_s_r;
                    end
                    if (scl_fall) begin
                        bit_cnt_nxt = 3'h0;
                        if (mack_r && !power_fail) begin
                            shift_nxt = rd_data;
                            rd_stb_nxt = 1'b1;
                            ptr_nxt = tws_next_ptr(ptr_r);
                            oe_nxt = ~rd_data[TWS_MSB];
                            state_nxt = TWS_ST_TX;
                        end else begin
                            oe_nxt = 1'b0;
                            state_nxt = TWS_ST_IGNORE;
                        end
                    end
                end
                TWS_ST_IGNORE: begin
                    oe_nxt = 1'b0;
                end
                default: begin
                    state_nxt = TWS_ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // Sequencer registers; the pointer is reset only here and survives transfers.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= TWS_ST_IDLE;
            phase_r <= TWS_PH_ADDR;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            ptr_r <= TWS_PTR_RESET;
            dir_r <= TWS_DIR_WRITE;
            mack_r <= 1'b0;
            oe_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
            rd_stb_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            ptr_r <= ptr_nxt;
            dir_r <= dir_nxt;
            mack_r <= mack_nxt;
            oe_r <= oe_nxt;
            wr_stb_r <= wr_stb_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
            rd_stb_r <= rd_stb_nxt;
        end
    end

    // Outputs straight from flops; the pin data is a constant low, drive is via enable.
    assign sda_out = 1'b0;
    assign sda_oe = oe_r;
    assign reg_ptr = ptr_r;
    assign wr_strobe = wr_stb_r;
    assign wr_addr = wr_addr_r;
    assign wr_data = wr_data_r;
    assign rd_strobe = rd_stb_r;
endmodule : tws_slave

// [design/tws_pkg.sv]
// Purpose: Shared constants and state types for the two-wire slave register port.
// Assumes: Register contents live outside the port and are reached through its strobes.
// Notes: Pointer locations 00h..05h; the pointer wraps from the last location to the first.
package tws_pkg;
    // Slave address and direction encoding.
    localparam logic [6:0] TWS_SLAVE_ADDR = 7'h68;
    localparam logic TWS_DIR_WRITE = 1'b0;
    localparam logic TWS_DIR_READ = 1'b1;

    // Register pointer range.
    localparam logic [7:0] TWS_PTR_FIRST = 8'h00;
    localparam logic [7:0] TWS_PTR_LAST = 8'h05;
    localparam logic [7:0] TWS_PTR_RESET = 8'h00;
    localparam logic [7:0] TWS_PTR_CNT_B0 = 8'h00;
    localparam logic [7:0] TWS_PTR_CNT_B3 = 8'h03;
    localparam logic [7:0] TWS_PTR_OSC_CTRL = 8'h04;
    localparam logic [7:0] TWS_PTR_TRICKLE = 8'h05;

    // Bit positions and counts.
    localparam int TWS_BITS_PER_BYTE = 8;
    localparam logic [2:0] TWS_LAST_BIT = 3'h7;
    localparam int TWS_MSB = 7;
    localparam int TWS_DIR_POS = 0;

    // Transfer sequencer states.
    typedef enum logic [2:0] {
        TWS_ST_IDLE,
        TWS_ST_RX,
        TWS_ST_RXEND,
        TWS_ST_ACK,
        TWS_ST_TX,
        TWS_ST_TXACK,
        TWS_ST_IGNORE
    } tws_state_e;

    // Meaning of the byte being received.
    typedef enum logic [1:0] {
        TWS_PH_ADDR,
        TWS_PH_PTR,
        TWS_PH_DATA
    } tws_phase_e;

    // Pointer advance with wrap from the last location back to the first.
    function automatic logic [7:0] tws_next_ptr(input logic [7:0] ptr);
        tws_next_ptr = (ptr >= TWS_PTR_LAST) ? TWS_PTR_FIRST : ptr + 8'h01;
    endfunction : tws_next_ptr
endpackage : tws_pkg

// [tb/tws_slave_sva.sv]
// Purpose: Assertions on the pins and strobes of the two-wire slave port.
// Assumes: Every SCL phase lasts several ref_clk cycles.
// Notes: Pins are watched before the slave's own synchronisers.
`timescale 1ns/1ps
module tws_slave_sva (
    // Clock, reset and bus pins.
    input wire logic ref_clk, reset, scl_in, sda_in, sda_out, sda_oe,
    // Register side and power monitor.
    input wire logic [7:0] reg_ptr, wr_addr, wr_data, rd_data,
    input wire logic wr_strobe, rd_strobe, power_fail
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Bus conditions as seen at the pins.
    sequence s_start; scl_in && $fell(sda_in); endsequence
    sequence s_stop; scl_in && $rose(sda_in); endsequence
    chk_oe_stable: assert property ($rose(scl_in) |-> $stable(sda_oe) [*6])
        else $error("sda_oe moved while scl high");
    chk_ack_hold: assert property ($rose(scl_in) && sda_oe |-> sda_oe [*6])
        else $error("sda_oe dropped inside a clock pulse");
    chk_start_free: assert property (s_start |=> !sda_oe [*8])
        else $error("slave drives sda after start");
    chk_stop_free: assert property (s_stop |-> !sda_oe [*8])
        else $error("slave drives sda after stop");
    chk_wr_wrap: assert property (wr_strobe |->
        reg_ptr == ((wr_addr >= 8'h05) ? 8'h00 : wr_addr + 8'h01))
        else $error("pointer not advanced after a write");
    chk_rd_wrap: assert property (rd_strobe |->
        reg_ptr == (($past(reg_ptr) >= 8'h05) ? 8'h00 : $past(reg_ptr) + 8'h01))
        else $error("pointer not advanced after a read");
    chk_pf_block: assert property (wr_strobe || rd_strobe |-> !$past(power_fail))
        else $error("register access during power fail");
    chk_open_drain: assert property (sda_out == 1'b0)
        else $error("sda driven high");
endmodule : tws_slave_sva
bind tws_slave tws_slave_sva i_tws_slave_sva (.*);

// [tb/tws_master_model.sv]
// Purpose: Behavioural two-wire bus master that clocks the slave port.
// Assumes: SCL bits take 13 and 12 ref_clk cycles in turn, a 125 ns period on average.
// Notes: SDA is only pulled low or released; the pull-up gives the high level.
`timescale 1ns/1ps
module tws_master_model (
    // Clock and bus.
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    // Bus starts idle with both lines released.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    // START is cond(0,1), also as a repeat from a low clock; STOP is cond(1,0).
    task automatic cond(input logic a, input logic b);
        sda_pull = a;
        tick(4);
        scl = 1'b1;
        tick(6);
        sda_pull = b;
        tick(6);
        scl = ~b;
        tick(3);
    endtask : cond
    // Eight data slots then the ninth; data changes only while SCL is low.
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_pull = ~d[i];
            tick(4);
            scl = 1'b1;
            tick(3);
            r[i] = sda;
            tick(3);
            scl = 1'b0;
            // Odd slots end one cycle early so two slots span 25 ref_clk cycles.
            tick(3 - (i % 2));
        end
    endtask : xfer
endmodule : tws_master_model

// [tb/tb.sv]
// Purpose: Self-checking bench for the two-wire slave register port.
// Assumes: A byte array behind the strobes stands in for the device registers.
// Notes: Each byte is compared with all nine slots as the wire shows them.
`timescale 1ns/1ps
module tb;
    import tws_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic power_fail = 1'b0;
    logic scl, sda_pull, sda_out, sda_oe, wr_strobe, rd_strobe;
    logic [7:0] reg_ptr, wr_addr, wr_data, rd_data;
    logic [7:0] mem [8] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37};
    int miscompares = 0;
    int num_checks = 0;
    int wr_count = 0;
    int rd_count = 0;
    // Open-drain line with pull-up: low while any party pulls.
    wire sda = ~(sda_pull | sda_oe);
    tws_slave i_tws_slave (.ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .reg_ptr(reg_ptr), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .power_fail(power_fail));
    tws_master_model i_tws_master_model (.ref_clk(ref_clk), .sda(sda), .scl(scl),
        .sda_pull(sda_pull));
    // Clock of 10 ns period.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Registers answer the pointer at once and take every write strobe.
    assign rd_data = mem[reg_ptr[2:0]];
    always @(posedge ref_clk) begin
        if (wr_strobe === 1'b1) mem[wr_addr[2:0]] <= wr_data;
        // Strobe counts let the scenarios see every store and every fetch.
        if (wr_strobe === 1'b1) wr_count++;
        if (rd_strobe === 1'b1) rd_count++;
    end
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One byte plus its ninth slot, compared with what the wire carried.
    task automatic xb(input logic [8:0] d, input logic [8:0] e);
        logic [8:0] r;
        i_tws_master_model.xfer(d, r);
        chk("wire", e, r);
    endtask : xb
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    // Pointer load, then stores that run across the wrap from 05h to 00h.
    task automatic t_write();
        i_tws_master_model.cond(1'b0, 1'b1);
        xb({TWS_SLAVE_ADDR, TWS_DIR_WRITE, 1'b1}, 9'h1a0);
        xb(9'h009, 9'h008);
        xb(9'h0b5, 9'h0b4);
        xb(9'h187, 9'h186);
        xb(9'h023, 9'h022);
        i_tws_master_model.cond(1'b1, 1'b0);
        chk("mem4", 9'h05a, {1'b0, mem[4]});
        chk("mem5", 9'h0c3, {1'b0, mem[5]});
        chk("mem0", 9'h011, {1'b0, mem[0]});
        chk("ptr", 9'h001, {1'b0, reg_ptr});
        chk("writes", 9'h003, 9'(wr_count));
        chk("reads", 9'h000, 9'(rd_count));
    endtask : t_write
    // Read from the kept pointer, end with NACK, then restart and read over the wrap.
    task automatic t_read();
        i_tws_master_model.cond(1'b0, 1'b1);
        xb({TWS_SLAVE_ADDR, TWS_DIR_READ, 1'b1}, 9'h1a2);
        xb(9'h1fe, 9'h062);
        xb(9'h1ff, 9'h065);
        i_tws_master_model.tick(6);
        chk("release", 9'h000, {8'h00, sda_oe});
        i_tws_master_model.cond(1'b0, 1'b1);
        xb(9'h1a1, 9'h1a0);
        xb(9'h00b, 9'h00a);
        i_tws_master_model.cond(1'b0, 1'b1);
        xb(9'h1a3, 9'h1a2);
        xb(9'h1fe, 9'h186);
        xb(9'h1ff, 9'h023);
        i_tws_master_model.cond(1'b1, 1'b0);
        chk("writes", 9'h003, 9'(wr_count));
        chk("reads", 9'h004, 9'(rd_count));
    endtask : t_read
    // A foreign address and a power fail are both refused; the pointer stays put.
    task automatic t_refuse();
        i_tws_master_model.cond(1'b0, 1'b1);
        xb(9'h141, 9'h141);
        xb(9'h1a1, 9'h1a1);
        i_tws_master_model.cond(1'b1, 1'b0);
        power_fail = 1'b1;
        i_tws_master_model.cond(1'b0, 1'b1);
        xb(9'h1a1, 9'h1a1);
        i_tws_master_model.cond(1'b1, 1'b0);
        power_fail = 1'b0;
        // Power fails after the address was taken, so the pointer byte is refused.
        i_tws_master_model.cond(1'b0, 1'b1);
        xb(9'h1a1, 9'h1a0);
        power_fail = 1'b1;
        xb(9'h007, 9'h007);
        i_tws_master_model.cond(1'b1, 1'b0);
        power_fail = 1'b0;
        chk("ptr", 9'h001, {1'b0, reg_ptr});
        chk("writes", 9'h003, 9'(wr_count));
        chk("reads", 9'h004, 9'(rd_count));
    endtask : t_refuse
    // Main sequence after 16 cycles of reset.
    initial begin
        repeat (16) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_write();
        t_read();
        t_refuse();
        end_of_test();
    end
    // Watchdog: the traffic needs about 23 us, so 200 us means a hang.
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
endmodule : tb
